// ### hdl/eomr_top.sv
// Purpose: eye opening monitor readout, counts and register view
// Assumes: register port from a bus target on core_clk_i;
//          comparator bits arrive on link_clk_i
// Notes:   link side counts errors, core side sequences and reads
`timescale 1ns/10ps
`include "eomr_defs.svh"

module eomr_top #(
   parameter int unsigned LOCK_PER_CYC =
      `EOMR_LOCK_PER_US * `EOMR_CLK_MHZ,
   parameter int unsigned ACC_SHIFT    = `EOMR_ACC_SHIFT
) (
   input  wire logic                core_clk_i,
   input  wire logic                rst_n_i,
   input  wire eomr_pkg::eomr_rreq_t reg_req_i,
   output logic [7:0]               reg_rdata_o,
   input  wire logic                lk_range_set_i,
   input  wire logic [1:0]          lk_range_i,
   output logic                     lock_loss_o,
   output logic [7:0]               fom_o,
   output logic [8:0]               range_mv_o,
   output logic                     eom_pwr_on_o,
   input  wire logic                link_clk_i,
   input  wire logic                prim_bit_i,
   input  wire logic                offs_bit_i,
   output logic [5:0]               offs_phase_o,
   output logic [5:0]               offs_volt_o
);
   localparam int SW = 9 + ACC_SHIFT;

   function automatic logic [15:0] sat_inc(input logic [15:0] c,
                                           input logic        e);
      return (e && c != `EOMR_CNT_MAX) ? c + 16'h1 : c;
   endfunction

   function automatic logic below(input logic [6:0] op,
                                  input logic [3:0] nib);
      return {1'b0, op} < (8'(nib) << `EOMR_THR_SHIFT);
   endfunction

   logic [7:0]        range_r, ovr_r, fast_r, acc_r, lock_r, thr_r;
   logic [7:0]        hopen_r, vopen_r, fom_r;
   logic              wr, rd, start_go, lk_go, per_hit, got, zero;
   logic [7:0]        ad, wd;
   eomr_pkg::eomr_st_t st_r;
   eomr_pkg::eomr_pt_t pt_r, pt_nxt;
   logic              lnch, rq_tgl_r, dn1_r, dn2_r, dn3_r;
   logic [19:0]       per_r;
   logic [15:0]       hold_r, pcnt_r;
   logic              lo_view_r, hi_done_r, lo_done_r, prime_r, pend_r;
   logic              prime2_r;
   logic [12:0]       words_r;
   logic              hi_rd, lo_rd, ld, swp_end, loss_r, pwr_r;
   logic [6:0]        oc_r, noc, hsave_r;
   logic [5:0]        first_r, nfirst, centre;
   // link domain
   logic              lr1_r, lr2_r, rq1_r, rq2_r, rq3_r;
   eomr_pkg::eomr_pt_t lpt_r;
   logic [15:0]       cnt_r, res_cnt_r;
   logic [SW-1:0]     smp_r, smp_last;
   logic              run_r, ltag_r, res_tag_r, dn_r, err;

   assign ad = reg_req_i.addr;
   assign wd = reg_req_i.wdata;
   assign wr = reg_req_i.wr;
   assign rd = reg_req_i.rd;

   // start only takes with fast mode set and the monitor powered
   assign start_go = wr && ad == `EOMR_A_FAST && wd[`EOMR_B_START] &&
                     wd[`EOMR_B_FAST] && !range_r[`EOMR_B_PD];
   assign per_hit  = per_r == 20'(LOCK_PER_CYC - 1);
   assign lk_go    = per_hit && lock_r[`EOMR_B_LKEN] && st_r ==
                     eomr_pkg::ST_IDLE;
   assign got      = (dn2_r ^ dn3_r) && res_tag_r == rq_tgl_r &&
                     st_r != eomr_pkg::ST_IDLE;
   assign zero     = res_cnt_r == 16'h0000;
   assign range_mv_o = 9'({7'h00, range_r[`EOMR_F_RANGE]} + 9'h1) *
                       `EOMR_MV_STEP;
   assign eom_pwr_on_o = pwr_r;
   assign lock_loss_o  = loss_r;
   assign fom_o        = fom_r;

   // range code: a controller write beats the lock logic
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         range_r <= `EOMR_RST_RANGE;
      end else if (wr && ad == `EOMR_A_RANGE) begin
         range_r <= wd;
      end else if (lk_range_set_i) begin
         range_r[`EOMR_F_RANGE] <= lk_range_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         ovr_r  <= `EOMR_RST_OVR;
         acc_r  <= `EOMR_RST_ACC;
         lock_r <= `EOMR_RST_LOCK;
         thr_r  <= `EOMR_RST_THR;
      end else if (wr) begin
         if (ad == `EOMR_A_OVR) begin
            ovr_r <= wd;
         end else if (ad == `EOMR_A_ACC) begin
            acc_r <= wd;
         end else if (ad == `EOMR_A_LOCK) begin
            lock_r <= wd;
         end else if (ad == `EOMR_A_THR) begin
            thr_r <= wd;
         end
      end
   end

   // a write in the end cycle wins over the self-clear
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         fast_r <= `EOMR_RST_FAST;
      end else if (wr && ad == `EOMR_A_FAST) begin
         fast_r <= wd;
         fast_r[`EOMR_B_START] <= start_go;
      end else if (swp_end) begin
         fast_r[`EOMR_B_START] <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         st_r <= eomr_pkg::ST_IDLE;
      end else if (start_go) begin
         st_r <= eomr_pkg::ST_SWP;
      end else begin
         case (st_r)
            eomr_pkg::ST_IDLE: begin
               if (lk_go) st_r <= eomr_pkg::ST_HSW;
            end
            eomr_pkg::ST_SWP: begin
               if (swp_end || !fast_r[`EOMR_B_FAST])
                  st_r <= eomr_pkg::ST_IDLE;
            end
            eomr_pkg::ST_HSW: begin
               if (got && pt_r.phase == `EOMR_LAST_STEP)
                  st_r <= eomr_pkg::ST_VSW;
            end
            eomr_pkg::ST_VSW: begin
               if (got && pt_r.volt == `EOMR_LAST_STEP)
                  st_r <= eomr_pkg::ST_IDLE;
            end
            default: st_r <= eomr_pkg::ST_IDLE;
         endcase
      end
   end

   // next grid point; voltage is the inner index of the sweep
   always_comb begin
      lnch = 1'b0;
      pt_nxt = pt_r;
      pt_nxt.acc = acc_r;
      if (start_go) begin
         lnch = 1'b1;
         pt_nxt.phase = 6'h00;
         pt_nxt.volt = 6'h00;
      end else begin
         case (st_r)
            eomr_pkg::ST_IDLE: begin
               if (lk_go) begin
                  lnch = 1'b1;
                  pt_nxt.phase = 6'h00;
                  pt_nxt.volt = `EOMR_MID_VOLT;
               end
            end
            eomr_pkg::ST_SWP: begin
               if (hi_rd && !prime_r &&
                   {pt_r.phase, pt_r.volt} != `EOMR_LAST_PT) begin
                  lnch = 1'b1;
                  {pt_nxt.phase, pt_nxt.volt} =
                     12'({pt_r.phase, pt_r.volt} + 12'h1);
               end
            end
            eomr_pkg::ST_HSW: begin
               if (got) begin
                  lnch = 1'b1;
                  if (pt_r.phase == `EOMR_LAST_STEP) begin
                     pt_nxt.phase = centre;
                     pt_nxt.volt = 6'h00;
                  end else begin
                     pt_nxt.phase = 6'(pt_r.phase + 6'h1);
                  end
               end
            end
            eomr_pkg::ST_VSW: begin
               if (got && pt_r.volt != `EOMR_LAST_STEP) begin
                  lnch = 1'b1;
                  pt_nxt.volt = 6'(pt_r.volt + 6'h1);
               end
            end
            default: lnch = 1'b0;
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         pt_r <= '0;
         rq_tgl_r <= 1'b0;
      end else if (lnch) begin
         pt_r <= pt_nxt;
         rq_tgl_r <= ~rq_tgl_r;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i || !lock_r[`EOMR_B_LKEN] || per_hit) begin
         per_r <= 20'h00000;
      end else begin
         per_r <= 20'(per_r + 20'h1);
      end
   end

   // readout: two dummy words lead, so the first four bytes are stale
   assign hi_rd = rd && ad == `EOMR_A_CNTH && !lo_view_r &&
                  st_r == eomr_pkg::ST_SWP;
   assign lo_rd = rd && st_r == eomr_pkg::ST_SWP &&
                  ((ad == `EOMR_A_CNTH && lo_view_r) ||
                   ad == `EOMR_A_CNTL);
   assign ld = pend_r && hi_done_r && lo_done_r && !prime2_r;
   assign swp_end = st_r == eomr_pkg::ST_SWP && hi_done_r &&
                    lo_done_r && words_r == `EOMR_WORDS;

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         hold_r <= 16'h0000;
         pcnt_r <= 16'h0000;
         lo_view_r <= 1'b0;
         hi_done_r <= 1'b0;
         lo_done_r <= 1'b0;
         prime_r <= 1'b0;
         prime2_r <= 1'b0;
         pend_r <= 1'b0;
         words_r <= 13'h0000;
      end else if (start_go) begin
         hold_r <= 16'h0000;
         lo_view_r <= 1'b0;
         hi_done_r <= 1'b0;
         lo_done_r <= 1'b0;
         prime_r <= 1'b1;
         prime2_r <= 1'b1;
         pend_r <= 1'b0;
         words_r <= 13'h0000;
      end else begin
         if (ld) begin
            hold_r <= pcnt_r;
            pend_r <= 1'b0;
            hi_done_r <= 1'b0;
            lo_done_r <= 1'b0;
            lo_view_r <= 1'b0;
         end
         // first dummy word done: rearm the flags for the second one
         if (prime2_r && hi_done_r && lo_done_r) begin
            prime2_r <= 1'b0;
            hi_done_r <= 1'b0;
            lo_done_r <= 1'b0;
            lo_view_r <= 1'b0;
         end
         if (got && st_r == eomr_pkg::ST_SWP) begin
            pend_r <= 1'b1;
            pcnt_r <= res_cnt_r;
         end
         if (hi_rd) begin
            hi_done_r <= 1'b1;
            lo_view_r <= 1'b1;
            if (!prime2_r) prime_r <= 1'b0;
            if (!prime_r) words_r <= 13'(words_r + 13'h1);
         end
         if (lo_rd) lo_done_r <= 1'b1;
      end
   end

   // opening search: zero-error points count as open
   assign noc    = 7'(oc_r + {6'h00, zero});
   assign nfirst = (zero && oc_r == 7'h00) ? pt_r.phase : first_r;
   assign centre = 6'(nfirst + {1'b0, noc[6:1]});

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         oc_r <= 7'h00;
         first_r <= 6'h00;
         hsave_r <= 7'h00;
         hopen_r <= 8'h00;
         vopen_r <= 8'h00;
         fom_r <= 8'h00;
         loss_r <= 1'b0;
      end else begin
         loss_r <= 1'b0;
         if (lk_go) begin
            oc_r <= 7'h00;
         end else if (got && st_r == eomr_pkg::ST_HSW) begin
            oc_r <= noc;
            first_r <= nfirst;
            if (pt_r.phase == `EOMR_LAST_STEP) begin
               hsave_r <= noc;
               oc_r <= 7'h00;
            end
         end else if (got && st_r == eomr_pkg::ST_VSW) begin
            oc_r <= noc;
            if (pt_r.volt == `EOMR_LAST_STEP) begin
               hopen_r <= {1'b0, hsave_r};
               vopen_r <= {1'b0, noc};
               fom_r <= 8'(hsave_r + noc);
               loss_r <= lock_r[`EOMR_B_LKEN] &&
                         (below(hsave_r, thr_r[`EOMR_F_THR_H]) ||
                          below(noc, thr_r[`EOMR_F_THR_V]));
            end
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         pwr_r <= 1'b0;
      end else begin
         pwr_r <= !range_r[`EOMR_B_PD] || st_r != eomr_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 8'h00;
      end else if (rd) begin
         if (ad == `EOMR_A_RANGE) reg_rdata_o <= range_r;
         else if (ad == `EOMR_A_OVR) reg_rdata_o <= ovr_r;
         else if (ad == `EOMR_A_FAST) reg_rdata_o <= fast_r;
         else if (ad == `EOMR_A_CNTH)
            reg_rdata_o <= lo_view_r ? hold_r[7:0] : hold_r[15:8];
         else if (ad == `EOMR_A_CNTL) reg_rdata_o <= hold_r[7:0];
         else if (ad == `EOMR_A_HOPEN) reg_rdata_o <= hopen_r;
         else if (ad == `EOMR_A_VOPEN) reg_rdata_o <= vopen_r;
         else if (ad == `EOMR_A_ACC) reg_rdata_o <= acc_r;
         else if (ad == `EOMR_A_LOCK) reg_rdata_o <= lock_r;
         else if (ad == `EOMR_A_THR) reg_rdata_o <= thr_r;
         else reg_rdata_o <= 8'h00;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         dn1_r <= 1'b0;
         dn2_r <= 1'b0;
         dn3_r <= 1'b0;
      end else begin
         dn1_r <= dn_r;
         dn2_r <= dn1_r;
         dn3_r <= dn2_r;
      end
   end

   // link side; pt_r is held still while its toggle crosses
   assign err = prim_bit_i ^ offs_bit_i;
   assign smp_last = SW'((SW'(lpt_r.acc) + SW'(1)) << ACC_SHIFT)
                     - SW'(1);
   assign offs_phase_o = lpt_r.phase;
   assign offs_volt_o  = lpt_r.volt;

   always_ff @(posedge link_clk_i) begin
      lr1_r <= rst_n_i;
      lr2_r <= lr1_r;
   end

   always_ff @(posedge link_clk_i) begin
      if (!lr2_r) begin
         rq1_r <= 1'b0;
         rq2_r <= 1'b0;
         rq3_r <= 1'b0;
      end else begin
         rq1_r <= rq_tgl_r;
         rq2_r <= rq1_r;
         rq3_r <= rq2_r;
      end
   end

   always_ff @(posedge link_clk_i) begin
      if (!lr2_r) begin
         lpt_r <= '0;
         ltag_r <= 1'b0;
         cnt_r <= 16'h0000;
         smp_r <= '0;
         run_r <= 1'b0;
         res_cnt_r <= 16'h0000;
         res_tag_r <= 1'b0;
         dn_r <= 1'b0;
      end else if (rq2_r != rq3_r) begin
         lpt_r <= pt_r;
         ltag_r <= rq2_r;
         cnt_r <= 16'h0000;
         smp_r <= '0;
         run_r <= 1'b1;
      end else if (run_r) begin
         cnt_r <= sat_inc(cnt_r, err);
         smp_r <= SW'(smp_r + SW'(1));
         if (smp_r == smp_last) begin
            run_r <= 1'b0;
            res_cnt_r <= sat_inc(cnt_r, err);
            res_tag_r <= ltag_r;
            dn_r <= ~dn_r;
         end
      end
   end

   a_pd_reset: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) $rose(rst_n_i) |-> range_r[`EOMR_B_PD])
      else $error("power-down not set after reset");
   a_range_write: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) wr && ad == `EOMR_A_RANGE |=>
      range_r[`EOMR_F_RANGE] == $past(wd[`EOMR_F_RANGE]))
      else $error("range write lost");
   a_range_lock: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) lk_range_set_i &&
      !(wr && ad == `EOMR_A_RANGE) |=>
      range_r[`EOMR_F_RANGE] == $past(lk_range_i))
      else $error("lock range not taken");
   a_start_go: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) start_go |=> st_r == eomr_pkg::ST_SWP
      && fast_r[`EOMR_B_START] && rq_tgl_r != $past(rq_tgl_r))
      else $error("start did not launch sweep");
   a_self_clear: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) swp_end && !wr |=>
      !fast_r[`EOMR_B_START] && st_r == eomr_pkg::ST_IDLE)
      else $error("start bit not self-cleared");
   a_hi_then_lo: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) hi_rd |=> lo_view_r &&
      reg_rdata_o == $past(hold_r[15:8]))
      else $error("high byte read did not expose low byte");
   a_advance: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) hi_rd && !prime_r && !start_go &&
      {pt_r.phase, pt_r.volt} != `EOMR_LAST_PT |=>
      {pt_r.phase, pt_r.volt} ==
      12'($past({pt_r.phase, pt_r.volt}) + 12'h1))
      else $error("grid point did not advance");
   a_hold_wait: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) !(hi_done_r && lo_done_r) && !start_go
      |=> $stable(hold_r))
      else $error("count loaded before both bytes read");
   a_open_read: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) rd && (ad == `EOMR_A_HOPEN ||
      ad == `EOMR_A_VOPEN) |=> reg_rdata_o == (($past(ad) ==
      `EOMR_A_HOPEN) ? $past(hopen_r) : $past(vopen_r)))
      else $error("opening readback wrong");
   a_loss_gate: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) lock_loss_o |->
      $past(lock_r[`EOMR_B_LKEN]) && $past(st_r) == eomr_pkg::ST_VSW)
      else $error("lock loss without lock monitor");
   a_cnt_sat: assert property (@(posedge link_clk_i)
      disable iff (!lr2_r) run_r && cnt_r == `EOMR_CNT_MAX &&
      rq2_r == rq3_r |=> cnt_r == `EOMR_CNT_MAX)
      else $error("error counter wrapped");

   c_sweep_end: cover property (@(posedge core_clk_i)
      disable iff (!rst_n_i) swp_end);
   c_lock_loss: cover property (@(posedge core_clk_i)
      disable iff (!rst_n_i) lock_loss_o);
   c_word_read: cover property (@(posedge core_clk_i)
      disable iff (!rst_n_i) hi_rd ##[1:40] lo_rd);
endmodule

// ### hdl/eomr_defs.svh
// Purpose: offsets, field positions, reset values and timing figures
// Assumes: byte-wide register port, 10 MHz core clock
// Notes:   included by the eye monitor readout top
`ifndef EOMR_DEFS_SVH
`define EOMR_DEFS_SVH
`define EOMR_A_RANGE    8'h11
`define EOMR_A_OVR      8'h22
`define EOMR_A_FAST     8'h24
`define EOMR_A_CNTH     8'h25
`define EOMR_A_CNTL     8'h26
`define EOMR_A_HOPEN    8'h27
`define EOMR_A_VOPEN    8'h28
`define EOMR_A_ACC      8'h2a
`define EOMR_A_LOCK     8'h3e
`define EOMR_A_THR      8'h6a
`define EOMR_B_PD       5
`define EOMR_F_RANGE    7:6
`define EOMR_B_FAST     7
`define EOMR_B_START    0
`define EOMR_B_LKEN     7
`define EOMR_F_THR_H    7:4
`define EOMR_F_THR_V    3:0
`define EOMR_RST_RANGE  8'h20
`define EOMR_RST_OVR    8'h00
`define EOMR_RST_FAST   8'h00
`define EOMR_RST_ACC    8'h0f
`define EOMR_RST_LOCK   8'h80
`define EOMR_RST_THR    8'h44
`define EOMR_THR_SHIFT  2
`define EOMR_MID_VOLT   6'h20
`define EOMR_LAST_STEP  6'h3f
`define EOMR_LAST_PT    12'hfff
`define EOMR_WORDS      13'h1000
`define EOMR_CNT_MAX    16'hffff
`define EOMR_MV_STEP    9'h064
`define EOMR_ACC_SHIFT  10
`define EOMR_CLK_MHZ    10
`define EOMR_LOCK_PER_US 10000
`endif

// ### hdl/eomr_pkg.sv
// Purpose: types shared by the eye monitor readout
// Assumes: nothing
// Notes:   register request travels as one struct
package eomr_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } eomr_rreq_t;
   typedef struct packed {
      logic [7:0] acc;
      logic [5:0] phase;
      logic [5:0] volt;
   } eomr_pt_t;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_SWP  = 4'h2,
      ST_HSW  = 4'h4,
      ST_VSW  = 4'h8
   } eomr_st_t;
endpackage

// ### sim/eomr_host.sv
// Purpose: controller and comparator model for the eye monitor readout
// Assumes: one request per call, launched at a rising core edge
// Notes:   offset comparator disagrees only above mid scale
`timescale 1ns/10ps
module eomr_host (
   input  wire logic            core_clk_i,
   input  wire logic            link_clk_i,
   input  wire logic [7:0]      reg_rdata_i,
   input  wire logic [5:0]      offs_volt_i,
   output eomr_pkg::eomr_rreq_t reg_req_o,
   output logic                 prim_bit_o,
   output logic                 offs_bit_o
);
   initial begin
      reg_req_o = '0;
      prim_bit_o = 1'b0;
   end
   // toggling data so a stuck compare path cannot hide
   always @(posedge link_clk_i) prim_bit_o <= ~prim_bit_o;
   assign offs_bit_o = prim_bit_o ^ (offs_volt_i > 6'h20);
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      reg_req_o <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge core_clk_i);
      reg_req_o <= '0;
   endtask
   // data is settled one cycle after the taking edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk_i);
      reg_req_o <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(posedge core_clk_i);
      reg_req_o <= '0;
      @(posedge core_clk_i);
      #1 d = reg_rdata_i;
   endtask
endmodule

// ### sim/tb_eomr_top.sv
// Purpose: self-checking bench for the eye monitor readout
// Assumes: short accumulation and lock period set by parameters
// Notes:   full 64 by 64 readout, alternating read styles
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
   errors++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_eomr_top;
   logic                 core_clk_i;
   logic                 link_clk_i;
   logic                 rst_n_i;
   eomr_pkg::eomr_rreq_t reg_req;
   logic [7:0]           reg_rdata;
   logic                 lk_range_set;
   logic [1:0]           lk_range;
   logic                 lock_loss;
   logic [7:0]           fom;
   logic [8:0]           range_mv;
   logic                 pwr_on;
   logic                 prim;
   logic                 offs;
   logic [5:0]           phase;
   logic [5:0]           volt;
   logic [7:0]           d;
   int                   errors = 0;
   int                   n_checks = 0;
   // samples per point are (0+1) shifted by ACC_SHIFT
   localparam logic [15:0] SAMP = 16'h0004;
   eomr_top #(.LOCK_PER_CYC(200), .ACC_SHIFT(2)) eomr_top_i (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_req_i(reg_req),
      .reg_rdata_o(reg_rdata), .lk_range_set_i(lk_range_set),
      .lk_range_i(lk_range), .lock_loss_o(lock_loss), .fom_o(fom),
      .range_mv_o(range_mv), .eom_pwr_on_o(pwr_on),
      .link_clk_i(link_clk_i), .prim_bit_i(prim), .offs_bit_i(offs),
      .offs_phase_o(phase), .offs_volt_o(volt));
   eomr_host eomr_host_i (
      .core_clk_i(core_clk_i), .link_clk_i(link_clk_i),
      .reg_rdata_i(reg_rdata), .offs_volt_i(volt), .reg_req_o(reg_req),
      .prim_bit_o(prim), .offs_bit_o(offs));
   initial begin
      core_clk_i = 1'b0;
      forever #50 core_clk_i = ~core_clk_i;
   end
   initial begin
      link_clk_i = 1'b0;
      #3.3;
      forever #7.5 link_clk_i = ~link_clk_i;
   end
   task automatic summarize();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // read before the first lock sweep can refresh the openings
   task automatic t_reset_vals();
      logic [7:0] a [9] = '{8'h11, 8'h22, 8'h24, 8'h2a, 8'h3e, 8'h6a,
                            8'h27, 8'h28, 8'h30};
      logic [7:0] v [9] = '{8'h20, 8'h00, 8'h00, 8'h0f, 8'h80, 8'h44,
                            8'h00, 8'h00, 8'h00};
      `CHK("range_mv", 9'd100, range_mv)
      `CHK("pwr_on", 1'b0, pwr_on)
      for (int i = 0; i < 9; i++) begin
         eomr_host_i.rd(a[i], d);
         `CHK("reset reg", v[i], d)
      end
   endtask
   task automatic t_range();
      for (int c = 0; c < 4; c++) begin
         eomr_host_i.wr(8'h11, {c[1:0], 6'h20});
         @(posedge core_clk_i);
         #1;
         `CHK("range_mv", 9'((c + 1) * 100), range_mv)
      end
      @(posedge core_clk_i);
      lk_range_set <= 1'b1;
      lk_range <= 2'h1;
      @(posedge core_clk_i);
      lk_range_set <= 1'b0;
      eomr_host_i.rd(8'h11, d);
      `CHK("lock range", 8'h60, d)
      `CHK("range_mv", 9'd200, range_mv)
      eomr_host_i.wr(8'h24, 8'h81);
      eomr_host_i.rd(8'h24, d);
      `CHK("start while off", 8'h80, d)
   endtask
   task automatic t_sweep();
      logic [15:0] e;
      logic [7:0]  lo_a;
      eomr_host_i.wr(8'h3e, 8'h00);
      eomr_host_i.wr(8'h22, 8'h00);
      eomr_host_i.wr(8'h2a, 8'h00);
      eomr_host_i.wr(8'h11, 8'h00);
      eomr_host_i.wr(8'h24, 8'h81);
      eomr_host_i.rd(8'h24, d);
      `CHK("start", 8'h81, d)
      `CHK("pwr_on", 1'b1, pwr_on)
      for (int i = 0; i < 4; i++) begin
         eomr_host_i.rd(8'h25, d);
         `CHK("dummy", 8'h00, d)
      end
      for (int k = 0; k < 4096; k++) begin
         repeat (10) @(posedge core_clk_i);
         e = (k[5:0] > 6'h20) ? SAMP : 16'h0000;
         lo_a = k[0] ? 8'h26 : 8'h25;
         eomr_host_i.rd(8'h25, d);
         `CHK("count hi", e[15:8], d)
         if (k == 64) begin
            eomr_host_i.rd(8'h2a, d);
            `CHK("acc between bytes", 8'h00, d)
         end
         eomr_host_i.rd(lo_a, d);
         `CHK("count lo", e[7:0], d)
      end
      `CHK("last phase", 6'h3f, phase)
      `CHK("last volt", 6'h3f, volt)
      eomr_host_i.rd(8'h24, d);
      `CHK("start cleared", 8'h80, d)
   endtask
   task automatic t_lock();
      eomr_host_i.wr(8'h24, 8'h00);
      eomr_host_i.wr(8'h11, 8'h20);
      eomr_host_i.wr(8'h6a, 8'h0f);
      eomr_host_i.wr(8'h3e, 8'h80);
      for (int i = 0; i < 5000 && lock_loss !== 1'b1; i++) begin
         @(posedge core_clk_i);
         #1;
      end
      `CHK("lock_loss", 1'b1, lock_loss)
      `CHK("centre phase", 6'h20, phase)
      eomr_host_i.rd(8'h27, d);
      `CHK("h opening", 8'h40, d)
      eomr_host_i.rd(8'h28, d);
      `CHK("v opening", 8'h21, d)
      `CHK("fom", 8'h61, fom)
   endtask
   initial begin
      rst_n_i = 1'b0;
      lk_range_set = 1'b0;
      lk_range = 2'h0;
      repeat (10) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      @(posedge core_clk_i);
      #1;
      t_reset_vals();
      t_range();
      t_sweep();
      t_lock();
      summarize();
   end
   // sweep dominates: about 66k cycles at sixteen per point
   initial begin
      #8500000;
      errors++;
      summarize();
   end
endmodule
